//--- core_acc_flags_pc_pointer.sv
// accumulator, status flags, program counter and pointer registers of the core
`timescale 1ns/1ns
`default_nettype none

module core_acc_flags_pc_pointer
  import core_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave, word addressed
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // decoder step
  input wire logic stepValid,
  input wire step_type stepOp,
  input wire logic [7:0] stepOperand,
  input wire logic [2:0] stepBitSel,
  input wire logic [11:0] stepTarget,
  input wire add_form_type stepAddForm,
  // alu result for STEP_ALU
  input wire logic [7:0] aluResult,
  input wire logic aluCarry,
  input wire logic aluHalfCarry,
  input wire logic aluWriteAcc,
  // supply detector and its option straps, asynchronous
  input wire logic supplyBelowHigh,
  input wire logic supplyBelowLow,
  input wire logic highDetectorOption,
  input wire logic midDetectorOption,
  input wire logic [1:0] resetCauseIn,
  // state seen by the rest of the core
  output logic [7:0] workAccumulator,
  output logic [7:0] programStatusFlags,
  output logic [11:0] programCounter,
  output logic [15:0] pointerAddress,
  output logic [7:0] memResult,
  output logic skipTaken
);

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] acc_ff, nxt_acc;
  logic [7:0] accBuf_ff, flagBuf_ff;
  logic [1:0] cause_ff;
  logic causeCaught_ff;
  logic carry_ff, half_ff, zero_ff;
  logic nxt_carry, nxt_half, nxt_zero;
  logic [3:0] pch_ff, nxt_pch;
  logic [7:0] pcl_ff, nxt_pcl;
  logic [7:0] ptrLow_ff, ptrHigh_ff;
  logic [7:0] memResult_ff;
  logic skipTaken_ff;
  logic [1:0] lvMeta_ff, lvSync_ff, optMeta_ff, optSync_ff;
  logic [31:0] readdata_ff;
  logic readDone_ff;

  logic [8:0] pclSum;
  logic [7:0] incVal, decVal, flagsNow;
  logic skipCond, busWr, busRdStart, pclCarryUp;

  // ****************************************
  // bus decode
  // ****************************************
  // reads take one wait cycle so read data comes from a flop; writes never wait
  assign busWr = write;
  assign busRdStart = read && !readDone_ff;
  assign waitrequest = busRdStart;
  assign readdata = readdata_ff;

  // detector bits are live, so they only exist on the synchronised wires
  assign flagsNow = {cause_ff, lvSync_ff[1] & optSync_ff[1], lvSync_ff[0] & optSync_ff[0],
    1'b0, carry_ff, half_ff, zero_ff};

  // read path: unmapped indices answer zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_ff <= BUS_ZERO;
      readDone_ff <= 1'b0;
    end else begin
      readDone_ff <= busRdStart;
      if (busRdStart) begin
        case (address)
          IDX_PTR_LOW: readdata_ff <= {24'h00_0000, ptrLow_ff};
          IDX_PTR_HIGH: readdata_ff <= {24'h00_0000, ptrHigh_ff};
          IDX_FLAGS: readdata_ff <= {24'h00_0000, flagsNow};
          IDX_PC_LOW: readdata_ff <= {24'h00_0000, pcl_ff};
          IDX_PC_HIGH: readdata_ff <= {28'h000_0000, pch_ff};
          default: readdata_ff <= BUS_ZERO;
        endcase
      end
    end
  end

  // ****************************************
  // synchronisers
  // ****************************************
  // detector and option levels cross in from the analog side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvMeta_ff <= 2'h0;
      lvSync_ff <= 2'h0;
      optMeta_ff <= 2'h0;
      optSync_ff <= 2'h0;
    end else begin
      lvMeta_ff <= {supplyBelowHigh, supplyBelowLow};
      lvSync_ff <= lvMeta_ff;
      optMeta_ff <= {highDetectorOption, midDetectorOption};
      optSync_ff <= optMeta_ff;
    end
  end

  // ****************************************
  // step arithmetic
  // ****************************************
  assign pclSum = {1'b0, pcl_ff} + {1'b0, acc_ff};
  assign incVal = stepOperand + BYTE_ONE;
  assign decVal = stepOperand - BYTE_ONE;
  // bank0 add never carries into the high byte; the plain and carry forms do
  assign pclCarryUp = pclSum[8] && (stepAddForm != ADD_BANK0);

  // skip condition of the current step
  always_comb begin
    skipCond = 1'b0;
    case (stepOp)
      STEP_CMP_SKIP: skipCond = (acc_ff == stepOperand);
      STEP_INC_SKIP, STEP_INC_MEM_SKIP: skipCond = (stepOperand == BYTE_FULL);
      STEP_DEC_SKIP, STEP_DEC_MEM_SKIP: skipCond = (stepOperand == BYTE_ONE);
      STEP_BIT_SKIP0: skipCond = !stepOperand[stepBitSel];
      STEP_BIT_SKIP1: skipCond = stepOperand[stepBitSel];
      default: skipCond = 1'b0;
    endcase
  end

  // ****************************************
  // program counter
  // ****************************************
  // a decoder step owns the counter; a bus write only lands when no step runs
  always_comb begin
    nxt_pch = pch_ff;
    nxt_pcl = pcl_ff;
    if (stepValid) begin
      case (stepOp)
        STEP_JUMP: {nxt_pch, nxt_pcl} = stepTarget;
        STEP_PC_ADD: begin
          nxt_pcl = pclSum[7:0];
          nxt_pch = pclCarryUp ? pch_ff + PCH_STEP : pch_ff;
        end
        STEP_PC_SUB: nxt_pcl = pcl_ff - acc_ff;
        default: {nxt_pch, nxt_pcl} = {pch_ff, pcl_ff} + (skipCond ? PC_SKIP : PC_STEP);
      endcase
    end else if (busWr && address == IDX_PC_LOW) begin
      nxt_pcl = writedata[7:0];
    end else if (busWr && address == IDX_PC_HIGH) begin
      nxt_pch = writedata[3:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pch_ff <= PC_RESET[11:8];
      pcl_ff <= PC_RESET[7:0];
    end else begin
      pch_ff <= nxt_pch;
      pcl_ff <= nxt_pcl;
    end
  end

  // ****************************************
  // accumulator and context buffers
  // ****************************************
  // interrupts never touch these: only explicit steps do
  always_comb begin
    nxt_acc = acc_ff;
    if (stepValid) begin
      case (stepOp)
        STEP_ALU: nxt_acc = aluWriteAcc ? aluResult : acc_ff;
        STEP_INC_SKIP: nxt_acc = incVal;
        STEP_DEC_SKIP: nxt_acc = decVal;
        STEP_RESTORE: nxt_acc = accBuf_ff;
        STEP_LOAD_ACC: nxt_acc = stepOperand;
        default: nxt_acc = acc_ff;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= REG_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accBuf_ff <= REG_RESET;
      flagBuf_ff <= REG_RESET;
    end else if (stepValid && stepOp == STEP_SAVE) begin
      accBuf_ff <= acc_ff;
      flagBuf_ff <= flagsNow;
    end
  end

  // memory-form result and skip indication for the decoder
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memResult_ff <= REG_RESET;
      skipTaken_ff <= 1'b0;
    end else begin
      skipTaken_ff <= stepValid && skipCond;
      if (stepValid && stepOp == STEP_INC_MEM_SKIP) begin
        memResult_ff <= incVal;
      end else if (stepValid && stepOp == STEP_DEC_MEM_SKIP) begin
        memResult_ff <= decVal;
      end
    end
  end

  // ****************************************
  // arithmetic flags
  // ****************************************
  // the alu reports carry in the no-borrow sense for subtracts, as the flags want
  always_comb begin
    nxt_carry = carry_ff;
    nxt_half = half_ff;
    nxt_zero = zero_ff;
    if (stepValid && stepOp == STEP_ALU) begin
      nxt_carry = aluCarry;
      nxt_half = aluHalfCarry;
      nxt_zero = (aluResult == BYTE_ZERO);
    end else if (stepValid && stepOp == STEP_CMP_SKIP) begin
      nxt_carry = (acc_ff >= stepOperand);
      nxt_zero = (acc_ff == stepOperand);
    end else if (stepValid && stepOp == STEP_RESTORE) begin
      nxt_carry = flagBuf_ff[BIT_CARRY];
      nxt_half = flagBuf_ff[BIT_HALF];
      nxt_zero = flagBuf_ff[BIT_ZERO];
    end else if (busWr && address == IDX_FLAGS) begin
      nxt_carry = writedata[BIT_CARRY];
      nxt_half = writedata[BIT_HALF];
      nxt_zero = writedata[BIT_ZERO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_ff <= 1'b0;
      half_ff <= 1'b0;
      zero_ff <= 1'b0;
    end else begin
      carry_ff <= nxt_carry;
      half_ff <= nxt_half;
      zero_ff <= nxt_zero;
    end
  end

  // ****************************************
  // reset cause
  // ****************************************
  // the cause level is caught on the first edge after release, never under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_ff <= CAUSE_WATCHDOG;
      causeCaught_ff <= 1'b0;
    end else begin
      causeCaught_ff <= 1'b1;
      if (!causeCaught_ff) begin
        cause_ff <= resetCauseIn;
      end else if (stepValid && stepOp == STEP_RESTORE) begin
        cause_ff <= flagBuf_ff[BIT_CAUSE_HI:BIT_CAUSE_LO];
      end else if (busWr && address == IDX_FLAGS) begin
        cause_ff <= writedata[BIT_CAUSE_HI:BIT_CAUSE_LO];
      end
    end
  end

  // ****************************************
  // pointer pair
  // ****************************************
  // plain working registers; together they address bank and location
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptrLow_ff <= REG_RESET;
      ptrHigh_ff <= REG_RESET;
    end else if (busWr && address == IDX_PTR_LOW) begin
      ptrLow_ff <= writedata[7:0];
    end else if (busWr && address == IDX_PTR_HIGH) begin
      ptrHigh_ff <= writedata[7:0];
    end
  end

  assign workAccumulator = acc_ff;
  assign programStatusFlags = flagsNow;
  assign programCounter = {pch_ff, pcl_ff};
  assign pointerAddress = {ptrHigh_ff, ptrLow_ff};
  assign memResult = memResult_ff;
  assign skipTaken = skipTaken_ff;

  // ****************************************
  // checks
  // ****************************************
  a_pc_advance_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_NEXT |=> programCounter == $past(programCounter) + PC_STEP)
    else $error("counter did not advance by one");

  a_jump_loads_target: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_JUMP |=> programCounter == $past(stepTarget))
    else $error("jump target not loaded");

  a_compare_skip_two: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_CMP_SKIP && acc_ff == stepOperand
    |=> programCounter == $past(programCounter) + PC_SKIP && skipTaken)
    else $error("equal compare did not skip");

  a_inc_wrap_skip: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_INC_SKIP && stepOperand == BYTE_FULL
    |=> programCounter == $past(programCounter) + PC_SKIP && workAccumulator == BYTE_ZERO)
    else $error("increment wrap did not skip");

  a_dec_no_skip: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_DEC_MEM_SKIP && stepOperand != BYTE_ONE
    |=> programCounter == $past(programCounter) + PC_STEP && !skipTaken)
    else $error("decrement skipped without reaching zero");

  a_bit_set_skip: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_BIT_SKIP1 && stepOperand[stepBitSel]
    |=> programCounter == $past(programCounter) + PC_SKIP)
    else $error("bit test did not skip");

  a_pcl_carry_up: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_PC_ADD && stepAddForm == ADD_PLAIN && pclSum[8]
    |=> programCounter[11:8] == $past(programCounter[11:8]) + PCH_STEP)
    else $error("low byte carry lost");

  a_pcl_borrow_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_PC_SUB |=> programCounter[11:8] == $past(programCounter[11:8]))
    else $error("high byte moved on subtract");

  a_alu_zero_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_ALU
    |=> programStatusFlags[BIT_ZERO] == ($past(aluResult) == BYTE_ZERO)
      && programStatusFlags[BIT_CARRY] == $past(aluCarry))
    else $error("alu flags not refreshed");

  // save and restore two cycles apart, as the decoder spaces its steps
  a_context_round: assert property (
    @(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_SAVE ##2 stepValid && stepOp == STEP_RESTORE
    |=> workAccumulator == $past(workAccumulator, 3))
    else $error("restore did not return saved accumulator");

  a_flag_bit_three: assert property (
    @(posedge clk) disable iff (!rst_n)
    read && !waitrequest && address == IDX_FLAGS |-> readdata[3] == 1'b0)
    else $error("flags bit three read as one");

  c_skip_taken: cover property (@(posedge clk) disable iff (!rst_n) skipTaken);
  c_pcl_carry: cover property (@(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_PC_ADD && pclCarryUp);
  c_restore: cover property (@(posedge clk) disable iff (!rst_n)
    stepValid && stepOp == STEP_RESTORE);
  c_bus_read: cover property (@(posedge clk) disable iff (!rst_n) read && !waitrequest);

endmodule // core_acc_flags_pc_pointer

`default_nettype wire

//--- core_regs_pkg.sv
// constants, offsets and step codes shared by the core working-register block
package core_regs_pkg;

  // register indices on the word-addressed bus (byte address is four times the index)
  localparam logic [7:0] IDX_PTR_LOW = 8'h80;
  localparam logic [7:0] IDX_PTR_HIGH = 8'h81;
  localparam logic [7:0] IDX_FLAGS = 8'h86;
  localparam logic [7:0] IDX_PC_LOW = 8'hCE;
  localparam logic [7:0] IDX_PC_HIGH = 8'hCF;

  // field positions inside program_status_flags
  localparam int BIT_CAUSE_HI = 7;
  localparam int BIT_CAUSE_LO = 6;
  localparam int BIT_LV_HIGH = 5;
  localparam int BIT_LV_LOW = 4;
  localparam int BIT_CARRY = 2;
  localparam int BIT_HALF = 1;
  localparam int BIT_ZERO = 0;

  // reset cause encodings on {reset_cause_hi, reset_cause_lo}
  localparam logic [1:0] CAUSE_WATCHDOG = 2'h0;
  localparam logic [1:0] CAUSE_RESERVED = 2'h1;
  localparam logic [1:0] CAUSE_LOW_VOLT = 2'h2;
  localparam logic [1:0] CAUSE_EXT_PIN = 2'h3;

  // reset values and step sizes
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam logic [11:0] PC_SKIP = 12'h002;
  localparam logic [3:0] PCH_STEP = 4'h1;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_FULL = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  // one instruction step as issued by the decoder
  typedef enum logic [3:0] {
    STEP_NEXT = 4'b0000,
    STEP_JUMP = 4'b0001,
    STEP_CMP_SKIP = 4'b0010,
    STEP_INC_SKIP = 4'b0011,
    STEP_INC_MEM_SKIP = 4'b0100,
    STEP_DEC_SKIP = 4'b0101,
    STEP_DEC_MEM_SKIP = 4'b0110,
    STEP_BIT_SKIP0 = 4'b0111,
    STEP_BIT_SKIP1 = 4'b1000,
    STEP_PC_ADD = 4'b1001,
    STEP_PC_SUB = 4'b1010,
    STEP_ALU = 4'b1011,
    STEP_SAVE = 4'b1100,
    STEP_RESTORE = 4'b1101,
    STEP_LOAD_ACC = 4'b1110
  } step_type;

  // add forms that may target the program counter low byte
  typedef enum logic [1:0] {
    ADD_PLAIN = 2'b00,
    ADD_CARRY = 2'b01,
    ADD_BANK0 = 2'b10
  } add_form_type;

endpackage

//--- alu_model.sv
// far-side adder standing in for the alu, feeding results into the core
`timescale 1ns/1ns
`default_nettype none

module alu_model (
  input wire logic [7:0] accIn,
  input wire logic [7:0] operandIn,
  output logic [7:0] sumOut,
  output logic carryOut,
  output logic halfOut
);
  logic [8:0] fullSum;
  logic [4:0] nibbleSum;

  // plain add; carry from bit 7, half-carry from the low nibble
  always_comb begin
    fullSum = {1'b0, accIn} + {1'b0, operandIn};
    nibbleSum = {1'b0, accIn[3:0]} + {1'b0, operandIn[3:0]};
    sumOut = fullSum[7:0];
    carryOut = fullSum[8];
    halfOut = nibbleSum[4];
  end
endmodule // alu_model

`default_nettype wire

//--- tb_top.sv
// self-checking bench for the core working-register block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import core_regs_pkg::*;
  logic clk, rst_n, read, write, stepValid, aluCarry, aluHalfCarry, aluWriteAcc, skipTaken;
  logic supplyBelowHigh, supplyBelowLow, highDetectorOption, midDetectorOption, waitrequest;
  logic [7:0] address, stepOperand, aluResult, workAccumulator, programStatusFlags, memResult;
  logic [31:0] writedata, readdata, q;
  logic [2:0] stepBitSel;
  logic [11:0] stepTarget, programCounter, mPc;
  logic [15:0] pointerAddress;
  logic [1:0] resetCauseIn;
  step_type stepOp;
  add_form_type stepAddForm;
  logic [7:0] mAcc, mF, mMem, sAcc, sF, lo, hi;
  int fail_count, samples_checked;
  step_type dOp [0:16];
  logic [7:0] dOpd [0:16];

  core_acc_flags_pc_pointer u_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .stepValid(stepValid), .stepOp(stepOp), .stepOperand(stepOperand), .stepBitSel(stepBitSel),
    .stepTarget(stepTarget), .stepAddForm(stepAddForm), .aluResult(aluResult),
    .aluCarry(aluCarry), .aluHalfCarry(aluHalfCarry), .aluWriteAcc(aluWriteAcc),
    .supplyBelowHigh(supplyBelowHigh), .supplyBelowLow(supplyBelowLow),
    .highDetectorOption(highDetectorOption), .midDetectorOption(midDetectorOption),
    .resetCauseIn(resetCauseIn), .workAccumulator(workAccumulator),
    .programStatusFlags(programStatusFlags), .programCounter(programCounter),
    .pointerAddress(pointerAddress), .memResult(memResult), .skipTaken(skipTaken));

  alu_model u_alu (.accIn(workAccumulator), .operandIn(stepOperand), .sumOut(aluResult),
    .carryOut(aluCarry), .halfOut(aluHalfCarry));

  // clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ***************************************
  // checking and closing
  // ***************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // flags as the model expects them; detector bits follow the gated inputs
  function automatic logic [7:0] expFlags();
    return {mF[7:6], supplyBelowHigh & highDetectorOption, supplyBelowLow & midDetectorOption,
      1'b0, mF[2:0]};
  endfunction

  // ***************************************
  // bus, reset and step drivers
  // ***************************************
  // request held until waitrequest is sampled low at a rising edge; read data taken there
  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    r = 32'h0000_0000;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) begin
        r = readdata;
        break;
      end
    end
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic doReset(input logic [1:0] c);
    @(posedge clk);
    resetCauseIn <= c;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    mPc = PC_RESET;
    mAcc = 8'h00;
    mMem = 8'h00;
    mF = {c, 6'h00};
    check(programCounter, mPc);
    check(programStatusFlags, expFlags());
    check(workAccumulator, mAcc);
  endtask

  task automatic doStep(input step_type op, input logic [7:0] opd, input logic [2:0] bs,
    input logic [11:0] tgt, input add_form_type form, input logic wAcc);
    logic skip;
    logic [8:0] s;
    skip = 1'b0;
    @(posedge clk);
    stepValid <= 1'b1;
    stepOp <= op;
    stepOperand <= opd;
    stepBitSel <= bs;
    stepTarget <= tgt;
    stepAddForm <= form;
    aluWriteAcc <= wAcc;
    @(posedge clk);
    stepValid <= 1'b0;
    // behavioural model of one step
    case (op)
      STEP_CMP_SKIP: begin
        skip = (mAcc == opd);
        mF[2] = (mAcc >= opd);
        mF[0] = skip;
      end
      STEP_INC_SKIP: begin
        mAcc = opd + 8'h01;
        skip = (opd == 8'hFF);
      end
      STEP_INC_MEM_SKIP: begin
        mMem = opd + 8'h01;
        skip = (opd == 8'hFF);
      end
      STEP_DEC_SKIP: begin
        mAcc = opd - 8'h01;
        skip = (opd == 8'h01);
      end
      STEP_DEC_MEM_SKIP: begin
        mMem = opd - 8'h01;
        skip = (opd == 8'h01);
      end
      STEP_BIT_SKIP0: skip = !opd[bs];
      STEP_BIT_SKIP1: skip = opd[bs];
      STEP_ALU: begin
        s = mAcc + opd;
        mF[2] = s[8];
        mF[1] = (mAcc[3:0] + opd[3:0]) > 15;
        mF[0] = (s[7:0] == 8'h00);
        if (wAcc) mAcc = s[7:0];
      end
      STEP_SAVE: begin
        sAcc = mAcc;
        sF = mF;
      end
      STEP_RESTORE: begin
        mAcc = sAcc;
        mF = sF;
      end
      STEP_LOAD_ACC: mAcc = opd;
      default: ;
    endcase
    if (op == STEP_JUMP) mPc = tgt;
    else if (op == STEP_PC_ADD) begin
      s = mPc[7:0] + mAcc;
      mPc = {mPc[11:8] + {3'b000, s[8] && form != ADD_BANK0}, s[7:0]};
    end else if (op == STEP_PC_SUB) mPc[7:0] = mPc[7:0] - mAcc;
    else mPc = mPc + (skip ? 12'h002 : 12'h001);
    #1;
    check(programCounter, mPc);
    check(skipTaken, skip);
    check(workAccumulator, mAcc);
    check(programStatusFlags, expFlags());
    check(memResult, mMem);
  endtask

  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    rst_n = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0000_0000;
    stepValid = 1'b0; stepOp = STEP_NEXT; stepOperand = 8'h00; stepBitSel = 3'h0;
    stepTarget = 12'h000; stepAddForm = ADD_PLAIN; aluWriteAcc = 1'b0; resetCauseIn = 2'h3;
    supplyBelowHigh = 1'b0; supplyBelowLow = 1'b0; highDetectorOption = 1'b0;
    midDetectorOption = 1'b0; fail_count = 0; samples_checked = 0;
    dOp = '{STEP_LOAD_ACC, STEP_CMP_SKIP, STEP_CMP_SKIP, STEP_CMP_SKIP, STEP_INC_SKIP,
      STEP_INC_SKIP, STEP_DEC_SKIP, STEP_DEC_SKIP, STEP_INC_MEM_SKIP, STEP_DEC_MEM_SKIP,
      STEP_DEC_MEM_SKIP, STEP_BIT_SKIP0, STEP_BIT_SKIP1, STEP_SAVE, STEP_ALU, STEP_RESTORE,
      STEP_NEXT};
    dOpd = '{8'h12, 8'h12, 8'h13, 8'h11, 8'hFF, 8'h10, 8'h01, 8'h00, 8'hFF, 8'h01, 8'h02,
      8'hFE, 8'hFE, 8'h00, 8'h01, 8'h00, 8'h00};
    void'($urandom(89));
    // every reset cause code, each through a fresh reset
    for (int c = 0; c < 4; c++) doReset(c[1:0]);
    // pointer pair, unmapped index, flags access kinds over the bus
    lo = 8'($urandom);
    hi = 8'($urandom);
    busXfer(1'b1, IDX_PTR_LOW, {24'h0, lo}, q);
    busXfer(1'b1, IDX_PTR_HIGH, {24'h0, hi}, q);
    busXfer(1'b1, 8'h10, 32'h0000_00AA, q);
    busXfer(1'b0, IDX_PTR_LOW, 32'h0, q);
    check(q, {24'h0, lo});
    busXfer(1'b0, IDX_PTR_HIGH, 32'h0, q);
    check(q, {24'h0, hi});
    check(pointerAddress, {hi, lo});
    busXfer(1'b0, 8'h10, 32'h0, q);
    check(q, 32'h0000_0000);
    busXfer(1'b1, IDX_FLAGS, 32'h0000_00FF, q);
    mF = 8'hC7;
    busXfer(1'b0, IDX_FLAGS, 32'h0, q);
    check(q, {24'h0, expFlags()});
    busXfer(1'b1, IDX_FLAGS, 32'h0000_0000, q);
    mF = 8'h00;
    // directed skip, save and restore cases
    for (int i = 0; i <= 16; i++) doStep(dOp[i], dOpd[i], 3'h0, 12'h000, ADD_PLAIN, 1'b1);
    // save then restore with nothing between, so the round-trip check sees it
    doStep(STEP_LOAD_ACC, 8'h5C, 3'h0, 12'h000, ADD_PLAIN, 1'b0);
    doStep(STEP_SAVE, 8'h00, 3'h0, 12'h000, ADD_PLAIN, 1'b0);
    doStep(STEP_RESTORE, 8'h00, 3'h0, 12'h000, ADD_PLAIN, 1'b0);
    // computed jumps with each add form and a borrowing subtract
    for (int f = 0; f < 3; f++) begin
      doStep(STEP_JUMP, 8'h00, 3'h0, 12'h3F0, ADD_PLAIN, 1'b0);
      doStep(STEP_LOAD_ACC, 8'h20, 3'h0, 12'h000, ADD_PLAIN, 1'b0);
      doStep(STEP_PC_ADD, 8'h00, 3'h0, 12'h000, add_form_type'(f), 1'b0);
      doStep(STEP_PC_SUB, 8'h00, 3'h0, 12'h000, ADD_PLAIN, 1'b0);
    end
    busXfer(1'b0, IDX_PC_LOW, 32'h0, q);
    check(q, {24'h0, mPc[7:0]});
    busXfer(1'b0, IDX_PC_HIGH, 32'h0, q);
    check(q, {28'h0, mPc[11:8]});
    busXfer(1'b1, IDX_PC_LOW, 32'h0000_005A, q);
    #1 mPc[7:0] = 8'h5A;
    check(programCounter, mPc);
    // detector flags under every option setting, supply above and below
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      supplyBelowHigh <= k[2];
      supplyBelowLow <= k[2];
      highDetectorOption <= k[0];
      midDetectorOption <= k[1];
      repeat (3) @(posedge clk);
      #1 check(programStatusFlags, expFlags());
    end
    // random steps
    for (int j = 0; j < 200; j++) begin
      doStep(step_type'($urandom_range(0, 14)), 8'($urandom), 3'($urandom),
        12'($urandom), add_form_type'($urandom_range(0, 2)), 1'($urandom));
    end
    summarize();
  end
endmodule // tb_top

`default_nettype wire
